// File: testbench/pmta_flash_model.sv
/*
 Flash array model that answers table reads after a set wait.
 Assumes one shared clock and the unit's one-cycle fl_rd pulse.
*/
`timescale 1ns/100ps
module pmta_flash_model
(
	input  wire logic                  sys_clk,     // Core clock
	input  wire logic                  srst,        // Sync reset
	input  wire pmta_pkg::pmta_fl_rd_t fl_rd,       // Read request
	input  wire logic [3:0]            lat,         // Extra wait cycles
	output logic                       fl_rd_valid, // Byte valid
	output logic [7:0]                 fl_rd_data   // Read byte
);
	import pmta_pkg::*;
	logic       pend;
	logic [3:0] cnt;
	logic [7:0] byte_q;
	// Idle data toggles so a stale byte never passes for an answer
	always @(posedge sys_clk)
	begin
		fl_rd_valid <= 1'b0;
		fl_rd_data  <= ~fl_rd_data;
		cnt         <= cnt - 4'h1;
		if (srst)
		begin
			pend       <= 1'b0;
			fl_rd_data <= 8'h5A;
		end
		else if (fl_rd.rd)
		begin
			pend   <= 1'b1;
			cnt    <= lat;
			byte_q <= {fl_rd.cfg_space, 7'h00} ^ fl_rd.byte_addr[7:0]
				^ fl_rd.byte_addr[20:13];
		end
		else if (pend && cnt == 4'h0)
		begin
			pend        <= 1'b0;
			fl_rd_valid <= 1'b1;
			fl_rd_data  <= byte_q;
		end
	end
endmodule

// File: testbench/testbench.sv
/*
 Self-checking bench for the table access unit.
 Assumes the package, design files and flash model are compiled first.
*/
`timescale 1ns/100ps
module testbench;
	import pmta_pkg::*;
	logic          sys_clk = 1'b0;
	logic          srst = 1'b1;
	logic          reg_wr = 1'b0;
	logic [1:0]    reg_sel = 2'h0;
	logic [7:0]    reg_wdata = 8'h00;
	logic [7:0]    reg_rdata;
	pmta_tbl_req_t tbl_req = '0;
	logic          tbl_busy;
	logic          long_wr_go = 1'b0;
	logic          erase_go = 1'b0;
	pmta_fl_rd_t   fl_rd;
	logic          fl_rd_valid;
	logic [7:0]    fl_rd_data;
	pmta_fl_wr_t   fl_wr;
	pmta_fl_er_t   fl_er;
	logic [3:0]    lat = 4'h0;
	int            n_fail = 0;
	int            checked = 0;
	logic [21:0]   p;
	logic [21:0]   n;
	logic [63:0]   d;
	// 200 MHz core clock
	always #2.5 sys_clk = ~sys_clk;
	pmta_table_access dut (.sys_clk, .srst, .reg_wr, .reg_sel, .reg_wdata,
		.reg_rdata, .tbl_req, .tbl_busy, .long_wr_go, .erase_go, .fl_rd,
		.fl_rd_valid, .fl_rd_data, .fl_wr, .fl_er);
	pmta_flash_model flash (.sys_clk, .srst, .fl_rd, .lat, .fl_rd_valid,
		.fl_rd_data);
	task end_sim;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task chk(input logic [63:0] got, input logic [63:0] exp);
		checked++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Every wait is bounded; running out ends the run
	task tmo;
		n_fail++;
		$display("ERROR %0t wait ran out", $time);
		end_sim;
	endtask
	task wreg(input logic [1:0] s, input logic [7:0] v);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_sel   <= s;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task rchk(input logic [1:0] s, input logic [7:0] e);
		@(posedge sys_clk);
		reg_sel <= s;
		repeat (2) @(posedge sys_clk);
		#1 chk(reg_rdata, e);
	endtask
	task setp(input logic [21:0] v);
		wreg(2'h1, {2'b00, v[21:16]});
		wreg(2'h2, v[15:8]);
		wreg(2'h3, v[7:0]);
	endtask
	task chkp(input logic [21:0] v);
		rchk(2'h1, {2'b00, v[21:16]});
		rchk(2'h2, v[15:8]);
		rchk(2'h3, v[7:0]);
	endtask
	task req(input logic r, input pmta_upd_t u);
		@(posedge sys_clk);
		tbl_req <= '{r, ~r, u};
		@(posedge sys_clk);
		tbl_req <= '0;
	endtask
	task tread(input pmta_upd_t u, input logic [21:0] a, input logic [21:0] e);
		int i;
		req(1'b1, u);
		#1;
		for (i = 0; fl_rd.rd !== 1'b1; i++)
		begin
			if (i == 4) tmo;
			@(posedge sys_clk) #1;
		end
		chk({fl_rd.cfg_space, fl_rd.byte_addr}, a);
		chk(tbl_busy, 1'b1);
		for (i = 0; tbl_busy !== 1'b0; i++)
		begin
			if (i == 40) tmo;
			@(posedge sys_clk) #1;
		end
		rchk(2'h0, {a[21], 7'h00} ^ a[7:0] ^ a[20:13]);
		chkp(e);
	endtask
	task pulse(input logic w);
		int i;
		@(posedge sys_clk);
		long_wr_go <= w;
		erase_go   <= ~w;
		@(posedge sys_clk);
		long_wr_go <= 1'b0;
		erase_go   <= 1'b0;
		#1;
		for (i = 0; (w ? fl_wr.go : fl_er.go) !== 1'b1; i++)
		begin
			if (i == 4) tmo;
			@(posedge sys_clk) #1;
		end
	endtask
	task t_regs;
		rchk(2'h0, 8'h00);
		chkp(22'h00_0000);
		wreg(2'h1, 8'hFF);
		rchk(2'h1, 8'h3F);
		wreg(2'h0, 8'hC3);
		rchk(2'h0, 8'hC3);
		$display("test regs done");
	endtask
	// All four update modes, each with a different flash wait
	task t_modes;
		p = 22'h20_0010;
		setp(p);
		for (int k = 0; k < 4; k++)
		begin
			lat <= 4'(k * 3);
			n = {p[21], p[20:0] + ((k == 2) ? 21'h1F_FFFF : 21'h00_0001)};
			n = (k == 0) ? p : n;
			tread(pmta_upd_t'(k), (k == 3) ? n : p, n);
			p = n;
		end
		setp(22'h1F_FFFF);
		tread(PMTA_UPD_POST_INC, 22'h1F_FFFF, 22'h00_0000);
		setp(22'h20_0000);
		tread(PMTA_UPD_POST_DEC, 22'h20_0000, 22'h3F_FFFF);
		$display("test modes done");
	endtask
	// Start mid-row so the holding index wraps from 7 to 0
	task t_write;
		p = 22'h20_1235;
		setp(p);
		for (int k = 0; k < 8; k++)
		begin
			wreg(2'h0, 8'h10 + 8'(k));
			req(1'b0, PMTA_UPD_POST_INC);
			d[((5 + k) % 8) * 8 +: 8] = 8'h10 + 8'(k);
		end
		setp(p);
		pulse(1'b1);
		chk({fl_wr.cfg_space, fl_wr.block}, {p[21], p[21:3]});
		chk(fl_wr.data, d);
		pulse(1'b1);
		chk(fl_wr.data, d);
		p = 22'h2A_BCFF;
		setp(p);
		pulse(1'b0);
		chk({fl_er.cfg_space, fl_er.block}, {p[21], p[21:6]});
		$display("test write done");
	endtask
	initial
	begin
		repeat (16) @(posedge sys_clk);
		srst <= 1'b0;
		t_regs;
		t_modes;
		t_write;
		end_sim;
	end
endmodule

// File: verilog/pmta_pkg.sv
/*
 Types for the program memory table access unit.
 Assumes pmta_regs.svh sits on the include path.
*/
package pmta_pkg;
	`include "pmta_regs.svh"
	// Pointer update mode of one table instruction
	typedef enum logic [1:0] {
		PMTA_UPD_NONE,
		PMTA_UPD_POST_INC,
		PMTA_UPD_POST_DEC,
		PMTA_UPD_PRE_INC
	} pmta_upd_t;
	// Request from the core: one table instruction
	typedef struct packed {
		logic      rd;
		logic      wr;
		pmta_upd_t upd;
	} pmta_tbl_req_t;
	// Request towards the flash array
	typedef struct packed {
		logic        rd;
		logic        cfg_space;
		logic [20:0] byte_addr;
	} pmta_fl_rd_t;
	typedef struct packed {
		logic        go;
		logic        cfg_space;
		logic [18:0] block;
		logic [63:0] data;
	} pmta_fl_wr_t;
	typedef struct packed {
		logic        go;
		logic        cfg_space;
		logic [15:0] block;
	} pmta_fl_er_t;
endpackage

// File: verilog/pmta_ptr_step.sv
/*
 Pointer step unit: applies one table pointer update.
 Assumes a pure combinational use by the table access unit.
*/
`timescale 1ns/100ps
`include "pmta_regs.svh"
module pmta_ptr_step
	import pmta_pkg::*;
(
	input  wire logic [21:0]         ptr,      // Current pointer
	input  wire pmta_pkg::pmta_upd_t upd,      // Requested update
	output logic [21:0]              acc_ptr,  // Pointer used for access
	output logic [21:0]              new_ptr   // Pointer after instruction
);
	// Step within low field only, top bit kept
	function automatic logic [21:0] step(input logic [21:0] p, input logic dn);
		logic [20:0] lo;
		lo = dn ? p[20:0] - `PMTA_ONE_LOW : p[20:0] + `PMTA_ONE_LOW;
		return {p[`PMTA_CFG_BIT], lo};
	endfunction

	// Select access and result pointers by mode
	always_comb
	begin
		acc_ptr = ptr;
		new_ptr = ptr;
		case (upd)
			PMTA_UPD_NONE:     new_ptr = ptr;
			PMTA_UPD_POST_INC: new_ptr = step(ptr, 1'b0);
			PMTA_UPD_POST_DEC: new_ptr = step(ptr, 1'b1);
			PMTA_UPD_PRE_INC:
			begin
				acc_ptr = step(ptr, 1'b0);
				new_ptr = acc_ptr;
			end
			default:           new_ptr = ptr;
		endcase
	end
endmodule

// File: verilog/pmta_regs.svh
/*
 Constants for the program memory table access unit: register selects,
 pointer field positions, the upper byte mask, reset values and the pointer step of one.
 Assumes inclusion by the package and the design files of this block.
*/
// Notes on behaviour
// - Eight-bit latch carries each table byte
// - Three byte registers form 22-bit pointer
// - Low 21 bits address 2 MB space
// - Top bit selects ID and configuration space
// - Auto increment/decrement touches low 21 bits only
// - Table read uses all pointer bits
// - Table write: bits 2..0 pick holding register
// - Long write: bits 21..3 pick 8-byte block
// - Erase: bits 21..6 pick 64-byte block
// - Four pointer updates: none, post+, post-, pre+
`ifndef PMTA_REGS_SVH
`define PMTA_REGS_SVH
`define PMTA_SEL_LATCH 2'h0
`define PMTA_SEL_PTRU  2'h1
`define PMTA_SEL_PTRH  2'h2
`define PMTA_SEL_PTRL  2'h3
`define PMTA_PTR_W     22
`define PMTA_LOW_W     21
`define PMTA_CFG_BIT   21
`define PMTA_HOLD_N    8
`define PMTA_UPPER_MASK 8'h3F
`define PMTA_RST_BYTE  8'h00
`define PMTA_RST_PTR   22'h00_0000
`define PMTA_ONE_LOW   21'h00_0001
`endif

// File: verilog/pmta_table_access.sv
/*
 Table access unit: pointer, latch and eight holding registers moving
 bytes between program flash and data RAM for table instructions.
 Assumes the core presents at most one table instruction or register
 access per cycle, and the flash answers a read with rd_valid later.
*/
`timescale 1ns/100ps
`include "pmta_regs.svh"
module pmta_table_access
	import pmta_pkg::*;
(
	input  wire logic                  sys_clk,     // 200 MHz core clock
	input  wire logic                  srst,        // Sync reset, high
	input  wire logic                  reg_wr,      // Register write strobe
	input  wire logic [1:0]            reg_sel,     // Register select
	input  wire logic [7:0]            reg_wdata,   // Register write data
	output logic [7:0]                 reg_rdata,   // Selected register
	input  wire pmta_pkg::pmta_tbl_req_t tbl_req,   // Table instruction
	output logic                       tbl_busy,    // Read in flight
	input  wire logic                  long_wr_go,  // Start long write
	input  wire logic                  erase_go,    // Start erase
	output pmta_pkg::pmta_fl_rd_t      fl_rd,       // Flash read request
	input  wire logic                  fl_rd_valid, // Flash read returns
	input  wire logic [7:0]            fl_rd_data,  // Flash read byte
	output pmta_pkg::pmta_fl_wr_t      fl_wr,       // Long write request
	output pmta_pkg::pmta_fl_er_t      fl_er        // Erase request
);
	logic [7:0]  table_data_latch;
	logic [7:0]  table_pointer_upper;
	logic [7:0]  table_pointer_high;
	logic [7:0]  table_pointer_low;
	logic [7:0]  hold [0:7];
	logic        busy;
	pmta_fl_rd_t rd_q;
	pmta_fl_wr_t wr_q;
	pmta_fl_er_t er_q;
	logic [7:0]  next_latch;
	logic [7:0]  next_upper;
	logic [7:0]  next_high;
	logic [7:0]  next_low;
	logic [7:0]  next_hold [0:7];
	logic        next_busy;
	pmta_fl_rd_t next_rd;
	pmta_fl_wr_t next_wr;
	pmta_fl_er_t next_er;
	logic [21:0] program_memory_pointer;
	logic [21:0] acc_ptr;
	logic [21:0] new_ptr;
	logic        take;
	logic [63:0] hold_flat;

	// Pointer joined from its three byte registers
	assign program_memory_pointer = {table_pointer_upper[5:0],
		table_pointer_high, table_pointer_low};

	// Table ops are ignored, not queued, while a read is in flight
	assign take = (tbl_req.rd | tbl_req.wr) & ~busy;

	pmta_ptr_step u_step (
		.ptr     (program_memory_pointer),
		.upd     (tbl_req.upd),
		.acc_ptr (acc_ptr),
		.new_ptr (new_ptr)
	);

	// Holding bytes packed for the long write, byte 0 low
	always_comb
	begin
		hold_flat = 64'h0000_0000_0000_0000;
		for (int i = 0; i < `PMTA_HOLD_N; i++)
			hold_flat[i*8 +: 8] = hold[i];
	end

	// Next state of registers and flash requests
	always_comb
	begin
		next_latch = table_data_latch;
		next_upper = table_pointer_upper;
		next_high  = table_pointer_high;
		next_low   = table_pointer_low;
		for (int i = 0; i < `PMTA_HOLD_N; i++)
			next_hold[i] = hold[i];
		next_busy = busy;
		next_rd   = '0;
		next_wr   = '0;
		next_er   = '0;
		if (reg_wr)
		begin
			case (reg_sel)
				`PMTA_SEL_LATCH: next_latch = reg_wdata;
				`PMTA_SEL_PTRU:  next_upper = reg_wdata & `PMTA_UPPER_MASK;
				`PMTA_SEL_PTRH:  next_high  = reg_wdata;
				`PMTA_SEL_PTRL:  next_low   = reg_wdata;
				default:         next_latch = table_data_latch;
			endcase
		end
		if (take)
		begin
			next_upper = {2'b00, new_ptr[21:16]};
			next_high  = new_ptr[15:8];
			next_low   = new_ptr[7:0];
			if (tbl_req.rd)
			begin
				next_rd.rd        = 1'b1;
				next_rd.cfg_space = acc_ptr[`PMTA_CFG_BIT];
				next_rd.byte_addr = acc_ptr[20:0];
				next_busy         = 1'b1;
			end
			else
				next_hold[acc_ptr[2:0]] = table_data_latch;
		end
		if (busy & fl_rd_valid)
		begin
			next_latch = fl_rd_data;
			next_busy  = 1'b0;
		end
		if (long_wr_go)
		begin
			next_wr.go        = 1'b1;
			next_wr.cfg_space = program_memory_pointer[`PMTA_CFG_BIT];
			next_wr.block     = program_memory_pointer[21:3];
			next_wr.data      = hold_flat;
		end
		if (erase_go)
		begin
			next_er.go        = 1'b1;
			next_er.cfg_space = program_memory_pointer[`PMTA_CFG_BIT];
			next_er.block     = program_memory_pointer[21:6];
		end
	end

	// Register stage; holding bytes survive until overwritten
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			table_data_latch    <= `PMTA_RST_BYTE;
			table_pointer_upper <= `PMTA_RST_BYTE;
			table_pointer_high  <= `PMTA_RST_BYTE;
			table_pointer_low   <= `PMTA_RST_BYTE;
			for (int i = 0; i < `PMTA_HOLD_N; i++)
				hold[i] <= `PMTA_RST_BYTE;
			busy <= 1'b0;
			rd_q <= '0;
			wr_q <= '0;
			er_q <= '0;
		end
		else
		begin
			table_data_latch    <= next_latch;
			table_pointer_upper <= next_upper;
			table_pointer_high  <= next_high;
			table_pointer_low   <= next_low;
			for (int i = 0; i < `PMTA_HOLD_N; i++)
				hold[i] <= next_hold[i];
			busy <= next_busy;
			rd_q <= next_rd;
			wr_q <= next_wr;
			er_q <= next_er;
		end
	end

	// Read-back register, registered so outputs come from flops
	logic [7:0] next_rdata;
	always_comb
	begin
		case (reg_sel)
			`PMTA_SEL_LATCH: next_rdata = next_latch;
			`PMTA_SEL_PTRU:  next_rdata = next_upper;
			`PMTA_SEL_PTRH:  next_rdata = next_high;
			`PMTA_SEL_PTRL:  next_rdata = next_low;
			default:         next_rdata = next_latch;
		endcase
	end
	always_ff @(posedge sys_clk)
	begin
		if (srst)
			reg_rdata <= `PMTA_RST_BYTE;
		else
			reg_rdata <= next_rdata;
	end

	assign tbl_busy = busy;
	assign fl_rd    = rd_q;
	assign fl_wr    = wr_q;
	assign fl_er    = er_q;

	// Checks beside the logic
	sequence s_post_inc;
		take && tbl_req.upd == PMTA_UPD_POST_INC;
	endsequence
	// Read take: a table read accepted while no read is in flight
	sequence s_rd_take;
		take && tbl_req.rd;
	endsequence
	a_ptr_low_step: assert property (
		@(posedge sys_clk) disable iff (srst)
		(s_post_inc and !reg_wr) |=> program_memory_pointer[20:0] ==
		$past(program_memory_pointer[20:0]) + 21'h00_0001)
		else $error("post increment wrong");
	a_ptr_top_kept: assert property (
		@(posedge sys_clk) disable iff (srst)
		take && !reg_wr |=> program_memory_pointer[21] ==
		$past(program_memory_pointer[21]))
		else $error("pointer top bit changed");
	a_rd_issue: assert property (
		@(posedge sys_clk) disable iff (srst)
		s_rd_take |=> fl_rd.rd && tbl_busy)
		else $error("read not issued");
	a_busy_wait: assert property (
		@(posedge sys_clk) disable iff (srst)
		busy && !fl_rd_valid |=> tbl_busy)
		else $error("busy dropped early");
	a_rd_addr_full: assert property (
		@(posedge sys_clk) disable iff (srst)
		take && tbl_req.rd && tbl_req.upd == PMTA_UPD_NONE |=>
		fl_rd.rd && {fl_rd.cfg_space, fl_rd.byte_addr} ==
		$past(program_memory_pointer))
		else $error("read address wrong");
	a_pre_inc_addr: assert property (
		@(posedge sys_clk) disable iff (srst)
		take && tbl_req.rd && tbl_req.upd == PMTA_UPD_PRE_INC |=>
		fl_rd.byte_addr == $past(program_memory_pointer[20:0]) + 21'h00_0001)
		else $error("pre increment address wrong");
	a_latch_load: assert property (
		@(posedge sys_clk) disable iff (srst)
		busy && fl_rd_valid |=> table_data_latch == $past(fl_rd_data))
		else $error("latch not loaded");
	// Any mode but pre-increment writes at the unchanged pointer
	a_hold_write: assert property (
		@(posedge sys_clk) disable iff (srst)
		take && tbl_req.wr && !tbl_req.rd && tbl_req.upd != PMTA_UPD_PRE_INC
		|=> hold[$past(program_memory_pointer[2:0])] ==
		$past(table_data_latch))
		else $error("holding byte not written");
	a_wr_block: assert property (
		@(posedge sys_clk) disable iff (srst)
		long_wr_go |=> fl_wr.go &&
		fl_wr.block == $past(program_memory_pointer[21:3]))
		else $error("long write block wrong");
	a_er_block: assert property (
		@(posedge sys_clk) disable iff (srst)
		erase_go |=> fl_er.go &&
		fl_er.block == $past(program_memory_pointer[21:6]))
		else $error("erase block wrong");
	a_ptr_join: assert property (
		@(posedge sys_clk) disable iff (srst)
		reg_wr && reg_sel == `PMTA_SEL_PTRL && !take |=>
		program_memory_pointer[7:0] == $past(reg_wdata))
		else $error("pointer low byte not joined");
endmodule
